// ===== hw/pwm_meter_map.svh
// Purpose: Constants for the duty-cycle phase meter
// Assumes: 20 MHz system clock
// Notes:   Timing counts derive from the printed figures
`ifndef PWM_METER_MAP_SVH
`define PWM_METER_MAP_SVH
`define CLK_HZ          20000000
`define COUNT_HZ        1000000
`define PRESCALE_N      (`CLK_HZ / `COUNT_HZ)
`define PRESCALE_RELOAD 5'h13
`define STAGE_W         8
`define CNT_W           16
`define CNT_ALL_ONES    16'hffff
`define CNT_ZERO        16'h0000
`define CNT_MSB         15
`define CNT_ONE         16'h0001
`define CNT_ERR_MIN     16'h8000
`define STAGE_ONE       8'h01
`define STAGE_MAX       8'hff
`define PRE_ZERO        5'h00
`define PRE_ONE         5'h01
`endif

// ===== hw/pwm_meter_pkg.sv
// Purpose: Types for the duty-cycle phase meter
// Assumes: Nothing beyond the map header
// Notes:   Holds types only
package pwm_meter_pkg;
  typedef enum logic [1:0] {
    st_count,
    st_capture,
    st_clear
  } meter_state_t;
  typedef logic [15:0] count_t;
endpackage

// ===== hw/duty_cycle_pulse_width_meter.sv
// Purpose: Measures high and low phase of a duty-cycle modulated sensor output
// Assumes: Sensor output asynchronous to clock; clock is 20 MHz
// Notes:   Counts a 1 MHz tick; down-counter mode selectable by a pin
// Contract
// - Strobe on every rising and falling edge
// - Capture count into the ended phase's latch
// - Clear counter after capture, then resume
// - Sixteen-bit counter, two 8-bit stages, 1 MHz
// - Hold high and low counts separately
// - Stable tick; only the count ratio matters
// - Prescale value n minus one divides by n
// - Down mode presets all ones, subtracts
// - Down mode times phases in input order, as up mode does
// - Low count is low time, high is high
// - High duration high time, low duration low
`timescale 1ns/10ps
`include "pwm_meter_map.svh"
`default_nettype none
module duty_cycle_pulse_width_meter (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  sensor_in,
  input  wire logic                  down_mode,
  output var  pwm_meter_pkg::count_t high_phase_time,
  output var  pwm_meter_pkg::count_t low_phase_time,
  output var  logic                  high_valid,
  output var  logic                  low_valid,
  output var  logic                  sample_strobe,
  output var  logic                  level_now,
  output var  logic                  link_error
);
  import pwm_meter_pkg::*;

  // Input synchroniser, three stages
  logic [2:0]   sync_q;
  logic [2:0]   sync_d;
  logic         level_q;
  logic         level_d;
  logic         edge_w;
  // Prescaler
  logic [4:0]   pre_q;
  logic [4:0]   pre_d;
  logic         tick_w;
  // Counter and sequencing
  logic [`STAGE_W-1:0] lo_stage_q;
  logic [`STAGE_W-1:0] lo_stage_d;
  logic [`STAGE_W-1:0] hi_stage_q;
  logic [`STAGE_W-1:0] hi_stage_d;
  meter_state_t st_q;
  meter_state_t st_d;
  logic         ended_high_q;
  logic         ended_high_d;
  count_t       high_q;
  count_t       high_d;
  count_t       low_q;
  count_t       low_d;
  logic         hv_q;
  logic         hv_d;
  logic         lv_q;
  logic         lv_d;
  logic         strobe_q;
  logic         strobe_d;
  logic         err_q;
  logic         err_d;
  logic         mode_q;
  logic         mode_d;
  count_t       count_w;
  count_t       elapsed_w;

  function automatic count_t elapsed(input count_t raw, input logic down);
    elapsed = down ? (`CNT_ALL_ONES - raw) : raw;
  endfunction

  assign count_w   = {hi_stage_q, lo_stage_q};
  assign elapsed_w = elapsed(count_w, mode_q);
  assign tick_w    = (pre_q == `PRE_ZERO);
  // Stable level once stages two and three agree
  assign edge_w    = (sync_q[2] == sync_q[1]) && (sync_q[1] != level_q);

  always_comb begin
    sync_d  = {sync_q[1:0], sensor_in};
    // Level moves only when the edge is accepted, so busy-window edges wait
    level_d = ((st_q == st_count) && edge_w) ? sync_q[1] : level_q;
    pre_d   = tick_w ? `PRESCALE_RELOAD : pre_q - `PRE_ONE;
  end

  always_comb begin
    st_d         = st_q;
    lo_stage_d   = lo_stage_q;
    hi_stage_d   = hi_stage_q;
    ended_high_d = ended_high_q;
    high_d       = high_q;
    low_d        = low_q;
    hv_d         = hv_q;
    lv_d         = lv_q;
    strobe_d     = 1'b0;
    err_d        = err_q;
    mode_d       = mode_q;
    case (st_q)
      st_count: begin
        if (edge_w) begin
          // Phase just ended is the opposite of the new level
          ended_high_d = ~sync_q[1];
          strobe_d     = 1'b1;
          st_d         = st_capture;
        end else if (tick_w) begin
          if (mode_q) begin
            {hi_stage_d, lo_stage_d} = count_w - `CNT_ONE;
          end else begin
            lo_stage_d = lo_stage_q + `STAGE_ONE;
            if (lo_stage_q == `STAGE_MAX) begin
              hi_stage_d = hi_stage_q + `STAGE_ONE;
            end
          end
          // Top bit of elapsed count signals a broken link
          err_d = elapsed(count_w, mode_q) >= `CNT_ERR_MIN;
        end
      end
      st_capture: begin
        if (ended_high_q) begin
          high_d = elapsed_w;
          hv_d   = 1'b1;
        end else begin
          low_d = elapsed_w;
          lv_d  = 1'b1;
        end
        // In either mode the phase that just ended is the one captured
        st_d = st_clear;
      end
      st_clear: begin
        mode_d = down_mode;
        if (down_mode) begin
          {hi_stage_d, lo_stage_d} = `CNT_ALL_ONES;
        end else begin
          {hi_stage_d, lo_stage_d} = `CNT_ZERO;
        end
        err_d = 1'b0;
        st_d  = st_count;
      end
      default: begin
        st_d = st_count;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_q       <= 3'h0;
      level_q      <= 1'b0;
      pre_q        <= `PRESCALE_RELOAD;
      lo_stage_q   <= 8'h00;
      hi_stage_q   <= 8'h00;
      st_q         <= st_count;
      ended_high_q <= 1'b0;
      high_q       <= `CNT_ZERO;
      low_q        <= `CNT_ZERO;
      hv_q         <= 1'b0;
      lv_q         <= 1'b0;
      strobe_q     <= 1'b0;
      err_q        <= 1'b0;
      mode_q       <= 1'b0;
    end else begin
      sync_q       <= sync_d;
      level_q      <= level_d;
      pre_q        <= pre_d;
      lo_stage_q   <= lo_stage_d;
      hi_stage_q   <= hi_stage_d;
      st_q         <= st_d;
      ended_high_q <= ended_high_d;
      high_q       <= high_d;
      low_q        <= low_d;
      hv_q         <= hv_d;
      lv_q         <= lv_d;
      strobe_q     <= strobe_d;
      err_q        <= err_d;
      mode_q       <= mode_d;
    end
  end

  assign high_phase_time = high_q;
  assign low_phase_time  = low_q;
  assign high_valid      = hv_q;
  assign low_valid       = lv_q;
  assign sample_strobe   = strobe_q;
  assign level_now       = level_q;
  assign link_error      = err_q;
endmodule
`default_nettype wire

// ===== sim/pwm_meter_chk.sv
// Purpose: Port assertions for the phase meter
// Assumes: One clock, async reset
// Notes:   Bound below
`timescale 1ns/10ps
`default_nettype none
module pwm_meter_chk (
  input wire logic                  clock, reset, sensor_in, down_mode,
  input wire pwm_meter_pkg::count_t high_phase_time, low_phase_time,
  input wire logic                  high_valid, low_valid, sample_strobe, level_now, link_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe too wide");
  a_strobe_edge: assert property (sample_strobe |-> level_now != $past(level_now, 2))
    else $error("strobe without edge");
  a_rise_keeps_low: assert property (sample_strobe && level_now |-> ##[1:3] low_valid)
    else $error("low count not kept");
  a_fall_keeps_high: assert property (sample_strobe && !level_now |-> ##[1:3] high_valid)
    else $error("high count not kept");
  a_high_hold: assert property (!$past(sample_strobe) && !$past(sample_strobe, 2)
    |-> $stable(high_phase_time)) else $error("high count moved");
  a_low_hold: assert property (!$past(sample_strobe) && !$past(sample_strobe, 2)
    |-> $stable(low_phase_time)) else $error("low count moved");
  a_valid_keep: assert property (!($fell(high_valid) || $fell(low_valid)))
    else $error("valid dropped");
  a_level_track: assert property ($stable(sensor_in) [*8] |-> level_now == sensor_in)
    else $error("level lags input");
  a_err_clear: assert property (sample_strobe |-> ##2 !link_error)
    else $error("error flag not cleared");
  cover property (sample_strobe && level_now);
  cover property (sample_strobe && !level_now);
  cover property (high_valid && low_valid && down_mode);
endmodule
bind duty_cycle_pulse_width_meter pwm_meter_chk u_chk (.clock(clock), .reset(reset),
  .sensor_in(sensor_in), .down_mode(down_mode), .high_phase_time(high_phase_time),
  .low_phase_time(low_phase_time), .high_valid(high_valid), .low_valid(low_valid),
  .sample_strobe(sample_strobe), .level_now(level_now), .link_error(link_error));
`default_nettype wire

// ===== sim/sensor_model.sv
// Purpose: Sensor with alternating high and low phases
// Assumes: Phase lengths in us
// Notes:   Finishes the current cycle after run drops, then rests low
`timescale 1ns/10ps
`default_nettype none
module sensor_model (
  output var logic        sensor_out,
  input wire logic        run,
  input wire logic [15:0] high_us,
  input wire logic [15:0] low_us
);
  initial sensor_out = 1'b0;
  // Phases stay far below 32 ms
  always begin
    wait (run);
    sensor_out = 1'b1;
    #(high_us * 1000);
    sensor_out = 1'b0;
    #(low_us * 1000);
  end
endmodule
`default_nettype wire

// ===== sim/duty_cycle_pulse_width_meter_tb.sv
// Purpose: Bench for the phase meter
// Assumes: 50 ns clock
// Notes:   Counts in 1 us ticks
`timescale 1ns/10ps
`default_nettype none
module duty_cycle_pulse_width_meter_tb;
  import pwm_meter_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, down_mode = 1'b0, run = 1'b0, sensor_in;
  logic [15:0] hi_us = 16'h0, lo_us = 16'h0;
  count_t      hi_t, lo_t;
  logic        hv, lv, stb, lvl, err;
  int          error_cnt = 0, tests_run = 0, cyc = 0;
  always #25 clock = ~clock;
  duty_cycle_pulse_width_meter u_duty_cycle_pulse_width_meter (.clock(clock), .reset(reset),
    .sensor_in(sensor_in), .down_mode(down_mode), .high_phase_time(hi_t), .low_phase_time(lo_t),
    .high_valid(hv), .low_valid(lv), .sample_strobe(stb), .level_now(lvl), .link_error(err));
  sensor_model u_sensor_model (.sensor_out(sensor_in), .run(run), .high_us(hi_us), .low_us(lo_us));
  task complete_run();
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) if (++cyc > 40000) begin
    error_cnt++;
    complete_run();
  end
  task check(string n, logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task edge_seen(logic e);
    @(posedge clock iff stb === 1'b1);
    check("level", {15'h0, lvl}, {15'h0, e});
  endtask
  task measure(logic dm, logic [15:0] h, logic [15:0] l);
    @(posedge clock);
    #1 down_mode = dm; hi_us = h; lo_us = l; run = 1'b1;
    edge_seen(1'b1);
    edge_seen(1'b0);
    edge_seen(1'b1);
    #1 run = 1'b0;
    repeat (4) @(posedge clock);
    check("high", {15'h0, hi_t >= h - 16'h2 && hi_t <= h + 16'h1}, 16'h1);
    check("low", {15'h0, lo_t >= l - 16'h2 && lo_t <= l + 16'h1}, 16'h1);
    check("valid", {14'h0, hv, lv}, 16'h3);
    check("error", {15'h0, err}, 16'h0);
    edge_seen(1'b0);
    repeat (l * 20 + 40) @(posedge clock);
  endtask
  task up_count_test();
    check("rst", {hi_t | lo_t}, 16'h0);
    measure(1'b0, 16'h96, 16'h5a);
  endtask
  task down_count_test();
    measure(1'b1, 16'h3c, 16'hc8);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    #1 reset = 1'b0;
    up_count_test();
    down_count_test();
    complete_run();
  end
endmodule
`default_nettype wire
